// ===== rtl/wdg_top.sv
// digital watchdog downcounter with its apb register, stop/wait gating and
// chip reset generation with the restart stabilisation delay.
// assumes one clock, synchronous active-low reset, option inputs held static,
// and stop/wake requests as one-cycle pulses from the processor core.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - counter reaching its end while armed asserts chip reset.
// - reset comes from counter bit 6 falling from one to zero.
// - software write clearing the msb bit resets the chip, armed or not.
// - register resets to fe: disarmed, all counter bits and msb set.
// - register bits reversed: bit 7 is counter lsb, bit 2 counter bit 5.
// - six period bits give 64 periods, 3072 to 196608 cycles.
// - with software activation, disarmed until software sets arm bit 0.
// - once armed, clearing the arm bit is ignored until chip reset.
// - with hardware activation the arm bit reads one and cannot change.
// - disarmed counter works as a plain 7-bit timer, msb bit on top.
// - disarmed, a stop instruction enters true stop mode.
// - hardware activation without stop gating turns stop into wait.
// - armed, stop gating with nmi pin low turns stop into wait.
// - stop gating with nmi pin high freezes counter and enters stop.
// - leaving stop by interrupt resumes counting from the held value.
// - counter clock is the internal clock divided by 12, then by the 256 prescaler.
// - timeout restarts chip like external reset, with delay, reloads counter.
// - at least 28 instructions run after activation before any reset.
module wdg_top
    import wdg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire wdg_pkg::wdg_opt_t opt_i,
    input wire wdg_pkg::wdg_cpu_t cpu_i,
    input wire wdg_pkg::wdg_apb_req_t apb_i,
    output wdg_pkg::wdg_apb_rsp_t apb_o,
    output logic chip_reset_o,
    output logic stop_mode_o,
    output logic wait_mode_o,
    output logic osc_run_o,
    output logic timeout_o
);

    import wdg_pkg::*;

    // the state of the block outside the clock chain held in wdg_tick_div
    typedef struct packed {
        logic [WDG_CNT_W-1:0] cnt;
        logic arm;
        wdg_mode_t mode;
        logic chip_rst;
        logic [WDG_STAB_W-1:0] stab;
        logic restart;
        logic timeout;
        wdg_apb_rsp_t rsp;
    } wdg_state_t;

    localparam wdg_apb_rsp_t WDG_RSP_IDLE = '{pready: 1'b0, pslverr: 1'b0, prdata: '0};

    wdg_state_t s_q;
    wdg_state_t s_d;
    wdg_state_t s_rst;

    logic tick_step;
    logic armed;
    logic counting;
    logic hit;
    logic setup_phase;
    logic access_phase;
    logic wr_take;
    logic [WDG_CNT_W-1:0] cnt_dec;
    logic [WDG_CNT_W-1:0] cnt_wr;
    logic arm_wr;
    logic sr_cleared;

    // register image from the live counter; bit order is reversed on purpose
    function automatic logic [7:0] wdg_encode(input logic [WDG_CNT_W-1:0] cnt,
                                              input logic armed_f);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < WDG_PERIOD_W; i++) begin
            r[WDG_PERIOD_HI_BIT - i] = cnt[i];
        end
        r[WDG_MSB_BIT] = cnt[WDG_CNT_MSB];
        r[WDG_ARM_BIT] = armed_f;
        return r;
    endfunction

    // counter value carried by a written register image
    function automatic logic [WDG_CNT_W-1:0] wdg_decode(input logic [7:0] r);
        logic [WDG_CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < WDG_PERIOD_W; i++) begin
            c[i] = r[WDG_PERIOD_HI_BIT - i];
        end
        c[WDG_CNT_MSB] = r[WDG_MSB_BIT];
        return c;
    endfunction

    // reset image: chip reset held with a full stabilisation delay ahead
    always_comb begin
        s_rst = '0;
        s_rst.cnt = wdg_decode(WDG_CTRL_RESET);
        s_rst.arm = WDG_CTRL_RESET[WDG_ARM_BIT];
        s_rst.mode = WDG_MODE_RUN;
        s_rst.chip_rst = 1'b1;
        s_rst.stab = WDG_STAB_LOAD;
        s_rst.restart = 1'b1;
        s_rst.timeout = 1'b0;
        s_rst.rsp = WDG_RSP_IDLE;
    end

    // hardware activation forces the arm state regardless of the stored bit
    assign armed = opt_i.hw_activation | s_q.arm;

    // the counter steps unless the chip is in reset or frozen in true stop
    assign counting = !s_q.chip_rst && (s_q.mode != WDG_MODE_STOP);

    wdg_tick_div u_tick_div (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(counting),
        .restart_i(s_q.restart),
        .tick_div12_o(),
        .tick_step_o(tick_step)
    );

    // apb phase decode
    assign setup_phase = apb_i.psel && !apb_i.penable;
    assign access_phase = apb_i.psel && apb_i.penable;
    assign hit = (apb_i.paddr == WDG_CTRL_OFFSET);
    // writes are ignored while the processor is held in reset
    assign wr_take = access_phase && s_q.rsp.pready && apb_i.pwrite && hit &&
                     !s_q.chip_rst;

    // fields of a write
    assign cnt_wr = wdg_decode(apb_i.pwdata[7:0]);
    assign arm_wr = apb_i.pwdata[WDG_ARM_BIT];
    assign sr_cleared = !apb_i.pwdata[WDG_MSB_BIT];

    // plain down count; wraps when used as a free timer
    assign cnt_dec = s_q.cnt - 1'b1;

    // next state
    always_comb begin
        s_d = s_q;
        s_d.restart = 1'b0;
        s_d.timeout = 1'b0;

        // bus answer: one wait-free access phase after each setup cycle
        s_d.rsp.pready = 1'b0;
        if (setup_phase && !s_q.rsp.pready) begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.pslverr = !hit;
            s_d.rsp.prdata = '0;
            if (hit) begin
                s_d.rsp.prdata[7:0] = wdg_encode(s_q.cnt, armed);
            end
        end else if (!access_phase) begin
            s_d.rsp.pslverr = 1'b0;
        end

        if (s_q.chip_rst) begin
            // stabilisation delay: counter and arm held at their reset values
            s_d.cnt = s_rst.cnt;
            s_d.arm = 1'b0;
            s_d.mode = WDG_MODE_RUN;
            s_d.restart = 1'b1;
            if (s_q.stab == '0) begin
                s_d.chip_rst = 1'b0;
            end else begin
                s_d.stab = s_q.stab - 1'b1;
            end
        end else begin
            // counting, frozen in true stop so the held value survives
            if (tick_step && counting) begin
                s_d.cnt = cnt_dec;
                // only the msb falling fires, so the low six bits set the period
                if (armed && s_q.cnt[WDG_CNT_MSB] && !cnt_dec[WDG_CNT_MSB]) begin
                    s_d.timeout = 1'b1;
                end
            end

            // register write: load at once, restart the step so a fresh
            // period is cut short only by a step generated in the write cycle
            if (wr_take) begin
                s_d.cnt = cnt_wr;
                s_d.restart = 1'b1;
                if (!opt_i.hw_activation) begin
                    s_d.arm = s_q.arm | arm_wr;
                end
                if (sr_cleared) begin
                    s_d.timeout = 1'b1;
                end
            end

            // power mode handling of a stop instruction
            unique case (s_q.mode)
                WDG_MODE_RUN: begin
                    if (cpu_i.stop_instr) begin
                        if (!armed) begin
                            s_d.mode = WDG_MODE_STOP;
                        end else if (!opt_i.stop_gating) begin
                            s_d.mode = WDG_MODE_WAIT;
                        end else if (!cpu_i.nonmaskable_irq_pin) begin
                            s_d.mode = WDG_MODE_WAIT;
                        end else begin
                            s_d.mode = WDG_MODE_STOP;
                        end
                    end
                end
                WDG_MODE_WAIT: begin
                    if (cpu_i.wake_irq) begin
                        s_d.mode = WDG_MODE_RUN;
                    end
                end
                WDG_MODE_STOP: begin
                    // counting resumes from the held count on the way out
                    if (cpu_i.wake_irq) begin
                        s_d.mode = WDG_MODE_RUN;
                    end
                end
                default: begin
                    s_d.mode = WDG_MODE_RUN;
                end
            endcase

            // timeout restarts everything but the bus answer like the external reset pin
            if (s_d.timeout) begin
                s_d.chip_rst = 1'b1;
                s_d.stab = WDG_STAB_LOAD;
                s_d.mode = WDG_MODE_RUN;
                s_d.cnt = s_rst.cnt;
                s_d.arm = 1'b0;
                s_d.restart = 1'b1;
            end
        end
    end

    // state register; the external reset loads the reset image s_rst directly
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= s_rst;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign apb_o = s_q.rsp;
    assign chip_reset_o = s_q.chip_rst;
    assign stop_mode_o = (s_q.mode == WDG_MODE_STOP);
    assign wait_mode_o = (s_q.mode == WDG_MODE_WAIT);
    assign osc_run_o = (s_q.mode != WDG_MODE_STOP);
    assign timeout_o = s_q.timeout;

endmodule

// ===== rtl/wdg_pkg.sv
// package for the digital watchdog downcounter: register map, field layout,
// reset values, timing counts and the bus carrier types.
// assumes a single 250 mhz core clock that also serves as the internal clock.
package wdg_pkg;

    // register map (byte address on the apb bus)
    localparam int WDG_ADDR_W = 12;
    localparam logic [WDG_ADDR_W-1:0] WDG_CTRL_OFFSET = 12'h0d8;

    // watchdog_count_control field layout
    localparam int WDG_ARM_BIT = 0;
    localparam int WDG_MSB_BIT = 1;
    localparam int WDG_PERIOD_LO_BIT = 2;
    localparam int WDG_PERIOD_HI_BIT = 7;
    localparam logic [7:0] WDG_CTRL_RESET = 8'hfe;

    // downcounter geometry
    localparam int WDG_CNT_W = 7;
    localparam int WDG_CNT_MSB = 6;
    localparam int WDG_PERIOD_W = 6;

    // clock chain: internal clock / 12, then a fixed prescaler into the counter
    localparam int WDG_DIV_INT = 12;
    localparam int WDG_PRESCALE = 256;
    localparam int WDG_DIV_W = 4;
    localparam int WDG_PRE_W = 8;
    localparam int WDG_PERIOD_MIN_CYC = 3072;
    localparam int WDG_PERIOD_MAX_CYC = 196608;
    localparam int WDG_STEP_CYC = WDG_DIV_INT * WDG_PRESCALE;

    // restart stabilisation delay, in internal clock cycles
    localparam int WDG_STAB_CYC = 2048;
    localparam int WDG_STAB_W = 12;
    localparam logic [WDG_STAB_W-1:0] WDG_STAB_LOAD = WDG_STAB_W'(WDG_STAB_CYC - 1);

    // apb data
    localparam int WDG_DATA_W = 32;

    // processor power mode as seen by the watchdog
    typedef enum logic [1:0] {
        WDG_MODE_RUN,
        WDG_MODE_WAIT,
        WDG_MODE_STOP
    } wdg_mode_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [WDG_ADDR_W-1:0] paddr;
        logic [WDG_DATA_W-1:0] pwdata;
    } wdg_apb_req_t;

    // apb answer from this slave
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [WDG_DATA_W-1:0] prdata;
    } wdg_apb_rsp_t;

    // factory options, static after power-up
    typedef struct packed {
        logic hw_activation;
        logic stop_gating;
    } wdg_opt_t;

    // processor power-mode requests
    typedef struct packed {
        logic stop_instr;
        logic wake_irq;
        logic nonmaskable_irq_pin;
    } wdg_cpu_t;

endpackage

// ===== rtl/wdg_tick_div.sv
// clock chain of the watchdog: divide-by-12 enable, then the prescaler that
// yields one counter step every 3072 internal clock cycles.
// assumes clk_i is the internal clock and rstn_i a synchronous active-low reset.
`timescale 1ns/1ps

module wdg_tick_div
    import wdg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic restart_i,
    output logic tick_div12_o,
    output logic tick_step_o
);

    typedef struct packed {
        logic [WDG_DIV_W-1:0] div;
        logic [WDG_PRE_W-1:0] pre;
        logic div12;
        logic step;
    } wdg_div_state_t;

    wdg_div_state_t s_q;
    wdg_div_state_t s_d;

    // restart clears the chain so a fresh load gets a full step unless a step is already registered
    always_comb begin
        s_d = s_q;
        s_d.div12 = 1'b0;
        s_d.step = 1'b0;
        if (restart_i) begin
            s_d.div = '0;
            s_d.pre = '0;
        end else if (run_i) begin
            if (s_q.div == WDG_DIV_W'(WDG_DIV_INT - 1)) begin
                s_d.div = '0;
                s_d.div12 = 1'b1;
                s_d.pre = s_q.pre + 1'b1; // wraps at 256
                s_d.step = (s_q.pre == WDG_PRE_W'(WDG_PRESCALE - 1));
            end else begin
                s_d.div = s_q.div + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_div12_o = s_q.div12;
    assign tick_step_o = s_q.step;

endmodule

// ===== testbench/wdg_chk.sv
// checker for the watchdog: bus answer, restart, mode changes.
// assumes it is bound onto wdg_top and sees only its ports.
`timescale 1ns/1ps
module wdg_chk
    import wdg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire wdg_pkg::wdg_opt_t opt_i,
    input wire wdg_pkg::wdg_cpu_t cpu_i,
    input wire wdg_pkg::wdg_apb_req_t apb_i,
    input wire wdg_pkg::wdg_apb_rsp_t apb_o,
    input wire logic chip_reset_o,
    input wire logic stop_mode_o,
    input wire logic wait_mode_o,
    input wire logic osc_run_o,
    input wire logic timeout_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // stop request that the block must act on; a held chip is left out
    wire logic stp = cpu_i.stop_instr && !cpu_i.wake_irq && !chip_reset_o;
    wire logic gated = opt_i.hw_activation && opt_i.stop_gating;
    // bus steps
    sequence s_setup;
        apb_i.psel && !apb_i.penable && !apb_o.pready;
    endsequence
    sequence s_clear;
        apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite &&
            apb_i.paddr == WDG_CTRL_OFFSET && !apb_i.pwdata[1] && !chip_reset_o;
    endsequence
    reset_hold_a: assert property ($rose(rstn_i) |-> chip_reset_o)
        else $error("chip reset low at release");
    ready_next_a: assert property (s_setup |=> apb_o.pready) else $error("no ready");
    ready_pulse_a: assert property (apb_o.pready |=> !apb_o.pready) else $error("long ready");
    unmapped_err_a: assert property (apb_o.pready && apb_i.paddr != WDG_CTRL_OFFSET
        |-> apb_o.pslverr && apb_o.prdata == '0) else $error("unmapped answer");
    msb_clear_a: assert property (s_clear |=> timeout_o) else $error("no reset");
    restart_hold_a: assert property (timeout_o |=> chip_reset_o [*8])
        else $error("restart too short");
    stop_osc_a: assert property (stop_mode_o |-> !osc_run_o) else $error("osc runs");
    hw_wait_a: assert property (opt_i.hw_activation && !opt_i.stop_gating
        |-> !stop_mode_o) else $error("stop entered");
    nmi_low_a: assert property (stp && gated && !cpu_i.nonmaskable_irq_pin
        |=> wait_mode_o && !stop_mode_o) else $error("no wait");
    nmi_high_a: assert property (stp && gated && cpu_i.nonmaskable_irq_pin
        |=> stop_mode_o) else $error("no stop");
    wake_run_a: assert property (cpu_i.wake_irq |=> !stop_mode_o && !wait_mode_o)
        else $error("no wake");
endmodule

bind wdg_top wdg_chk u_wdg_chk (.clk_i(clk_i), .rstn_i(rstn_i), .opt_i(opt_i), .cpu_i(cpu_i),
    .apb_i(apb_i), .apb_o(apb_o), .chip_reset_o(chip_reset_o), .stop_mode_o(stop_mode_o),
    .wait_mode_o(wait_mode_o), .osc_run_o(osc_run_o), .timeout_o(timeout_o));

// ===== testbench/wdg_top_bench.sv
// self-checking bench for wdg_top: register, counting, timeouts, stop modes.
// assumes the wdg_pkg constants and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module wdg_top_bench;
    import wdg_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    wdg_opt_t opt = '0;
    wdg_cpu_t cpu = '0;
    wdg_apb_req_t req = '0;
    wdg_apb_rsp_t rsp;
    logic chip_rst, stop_m, wait_m, osc, tmo, err;
    logic [31:0] rd;
    logic [7:0] v;
    int errors = 0;
    int check_count = 0;
    int n;
    wdg_top u_wdg_top (.clk_i(clk_i), .rstn_i(rstn_i), .opt_i(opt), .cpu_i(cpu),
        .apb_i(req), .apb_o(rsp), .chip_reset_o(chip_rst), .stop_mode_o(stop_m),
        .wait_mode_o(wait_m), .osc_run_o(osc), .timeout_o(tmo));
    // 250 mhz clock
    always #2 clk_i = ~clk_i;
    // counter one step lower, in the reversed register layout
    function automatic logic [7:0] dec(input logic [7:0] r);
        logic [6:0] c;
        logic [7:0] o;
        o = r;
        for (int i = 0; i < 6; i++) c[i] = r[7-i];
        c[6] = r[1];
        c = c - 7'h01;
        for (int i = 0; i < 6; i++) o[7-i] = c[i];
        o[1] = c[6];
        return o;
    endfunction
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        if (k >= 20) errors++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // bounded wait for the chip to come out of reset
    task automatic settle();
        n = 0;
        while (chip_rst !== 1'b0 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic boot(input logic hw, input logic gate);
        opt <= '{hw_activation: hw, stop_gating: gate};
        rstn_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        settle();
        `CHK(n >= 2047 && n <= 2051, 1'b1)
        apb(1'b0, WDG_CTRL_OFFSET, 8'h00);
        `CHK(rd, {24'h0, hw ? 8'hff : WDG_CTRL_RESET})
    endtask
    // stop (with nmi level) or wake, one cycle wide
    task automatic pulse(input logic stop, input logic nmi);
        @(posedge clk_i);
        cpu <= '{stop_instr: stop, wake_irq: !stop, nonmaskable_irq_pin: nmi};
        @(posedge clk_i);
        cpu <= '0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard, about three times the expected run
    initial begin
        #400000;
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'he348f192));
        boot(1'b0, 1'b0);
        // first image puts the counter at 40: msb falls while disarmed
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h02 : ((8'($urandom) & 8'hfc) | 8'h02);
            apb(1'b1, WDG_CTRL_OFFSET, v);
            apb(1'b0, WDG_CTRL_OFFSET, 8'h00);
            `CHK(rd[7:0], v)
            repeat (3080) @(posedge clk_i);
            apb(1'b0, WDG_CTRL_OFFSET, 8'h00);
            `CHK(rd[7:0], dec(v))
            apb(1'b0, WDG_CTRL_OFFSET ^ {4'h0, 6'($urandom_range(1, 63)), 2'b00}, 8'h00);
            `CHK({err, rd}, 33'h1_0000_0000)
        end
        apb(1'b1, WDG_CTRL_OFFSET, 8'hfc);
        @(posedge clk_i);
        `CHK(tmo, 1'b1)
        settle();
        apb(1'b0, WDG_CTRL_OFFSET, 8'h00);
        `CHK(rd[7:0], WDG_CTRL_RESET)
        apb(1'b1, WDG_CTRL_OFFSET, 8'hff);
        apb(1'b1, WDG_CTRL_OFFSET, 8'hfe);
        apb(1'b0, WDG_CTRL_OFFSET, 8'h00);
        `CHK(rd[7:0], 8'hff)
        // shortest period: one step from 40 drops the msb
        apb(1'b1, WDG_CTRL_OFFSET, 8'h03);
        n = 0;
        while (tmo !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n >= 3068 && n <= 3078, 1'b1)
        settle();
        pulse(1'b1, 1'b0);
        `CHK(stop_m, 1'b1)
        pulse(1'b0, 1'b0);
        boot(1'b1, 1'b0);
        pulse(1'b1, 1'b1);
        `CHK({stop_m, wait_m}, 2'b01)
        pulse(1'b0, 1'b0);
        boot(1'b1, 1'b1);
        v = 8'hfb;
        apb(1'b1, WDG_CTRL_OFFSET, v);
        pulse(1'b1, 1'b1);
        repeat (4000) @(posedge clk_i);
        `CHK({stop_m, osc}, 2'b10)
        pulse(1'b0, 1'b0);
        apb(1'b0, WDG_CTRL_OFFSET, 8'h00);
        `CHK(rd[7:0], v)
        pulse(1'b1, 1'b0);
        repeat (3080) @(posedge clk_i);
        `CHK(wait_m, 1'b1)
        pulse(1'b0, 1'b0);
        apb(1'b0, WDG_CTRL_OFFSET, 8'h00);
        `CHK(rd[7:0], dec(v))
        conclude();
    end
endmodule
